// file: sa_flow_lookup_regs.vh
// field positions, encodings and limits for the sa flow lookup
`ifndef SA_FLOW_LOOKUP_REGS_VH
`define SA_FLOW_LOOKUP_REGS_VH

// packet key layout, low bit first
`define KEY_W 285
`define KEY_DA_LO 0
`define KEY_SA_LO 48
`define KEY_ET_LO 96
`define KEY_VFLAG_LO 112
`define KEY_UP_LO 116
`define KEY_VID_LO 119
`define KEY_IUP_LO 131
`define KEY_IVID_LO 134
`define KEY_PORT_LO 146
`define KEY_CTRL_LO 148
`define KEY_SCI_LO 149
`define KEY_TCI_LO 213
`define KEY_HBP_LO 221

// criterion mask layout
`define MASK_W 96
`define MASK_DA_LO 0
`define MASK_SA_LO 6
`define MASK_ET 12
`define MASK_VFLAG_LO 13
`define MASK_UP 17
`define MASK_VID 18
`define MASK_IUP 19
`define MASK_IVID 20
`define MASK_PORT 21
`define MASK_CTRL 22
`define MASK_SCI 23
`define MASK_TCI_LO 24
`define MASK_HBP_LO 32

// tag categories, also the permit bit positions
`define TAG_UNTAGGED 2'h0
`define TAG_TAGGED 2'h1
`define TAG_BAD 2'h2
`define TAG_KAY 2'h3

`define PRIO_W 4
`define NM_FLOWS 8

// flow types
`define FT_BYPASS 2'h0
`define FT_DROP 2'h1
`define FT_XFORM 2'h2

// drop actions
`define DROP_CRC 2'h0
`define DROP_PKT_ERR 2'h1
`define DROP_INTERNAL 2'h2

`define LOWER_W 32

`endif

// file: flow_matcher.v
// one flow's match test against a packet key
`default_nettype none
`include "sa_flow_lookup_regs.vh"

module flow_matcher #(
  parameter INGRESS = 1
) (
  input wire [`KEY_W-1:0] pkt_key,
  input wire [1:0] pkt_tag,
  input wire hdr_bypass_mode,
  input wire [`KEY_W-1:0] flow_match_values,
  input wire [`MASK_W-1:0] flow_criterion_mask,
  input wire [3:0] flow_tag_category_permit,
  input wire flow_enabled,
  output wire hit
);
  wire [`KEY_W-1:0] bit_mask;
  wire tagged_ingress;
  genvar b;

  // secure channel fields only exist in ingress tagged frames
  assign tagged_ingress = (INGRESS != 0) && (pkt_tag == `TAG_TAGGED);

  generate
    for (b = 0; b < 12; b = b + 1) begin : addr_bytes
      assign bit_mask[b*8 +: 8] = {8{flow_criterion_mask[`MASK_DA_LO + b]}};
    end
    for (b = 0; b < 4; b = b + 1) begin : vlan_flags
      assign bit_mask[`KEY_VFLAG_LO + b] = flow_criterion_mask[`MASK_VFLAG_LO + b];
    end
    for (b = 0; b < 8; b = b + 1) begin : tci_bits
      assign bit_mask[`KEY_TCI_LO + b] = flow_criterion_mask[`MASK_TCI_LO + b] &
                                         tagged_ingress;
    end
    for (b = 0; b < 64; b = b + 1) begin : hbp_bits
      assign bit_mask[`KEY_HBP_LO + b] = flow_criterion_mask[`MASK_HBP_LO + b] &
                                         hdr_bypass_mode;
    end
  endgenerate

  assign bit_mask[`KEY_ET_LO +: 16] = {16{flow_criterion_mask[`MASK_ET]}};
  assign bit_mask[`KEY_UP_LO +: 3] = {3{flow_criterion_mask[`MASK_UP]}};
  assign bit_mask[`KEY_VID_LO +: 12] = {12{flow_criterion_mask[`MASK_VID]}};
  assign bit_mask[`KEY_IUP_LO +: 3] = {3{flow_criterion_mask[`MASK_IUP]}};
  assign bit_mask[`KEY_IVID_LO +: 12] = {12{flow_criterion_mask[`MASK_IVID]}};
  assign bit_mask[`KEY_PORT_LO +: 2] = {2{flow_criterion_mask[`MASK_PORT]}};
  assign bit_mask[`KEY_CTRL_LO] = flow_criterion_mask[`MASK_CTRL];
  assign bit_mask[`KEY_SCI_LO +: 64] = {64{flow_criterion_mask[`MASK_SCI] & tagged_ingress}};

  // clear mask bit ignores the criterion; permit bit gates the category
  assign hit = flow_enabled & flow_tag_category_permit[pkt_tag] &
               ~|((pkt_key ^ flow_match_values) & bit_mask);
endmodule
`default_nettype wire

// file: macsec_sa_flow_lookup.v
// sa flow lookup with fallback flows, enable control and packet actions
`default_nettype none
`include "sa_flow_lookup_regs.vh"

module macsec_sa_flow_lookup #(
  parameter NUM_FLOWS = 64,
  parameter INGRESS = 1,
  parameter DATA_W = 64,
  parameter OCC_W = 8
) (
  input wire sys_clk,
  input wire rst,
  // packet stream, classification results valid with in_sop
  input wire in_valid,
  input wire in_sop,
  input wire in_eop,
  input wire [DATA_W-1:0] in_data,
  input wire [`KEY_W-1:0] pkt_key,
  input wire [1:0] pkt_tag,
  input wire hdr_bypass_mode,
  // flow table configuration
  input wire [NUM_FLOWS*`KEY_W-1:0] flow_match_values,
  input wire [NUM_FLOWS*`MASK_W-1:0] flow_criterion_mask,
  input wire [NUM_FLOWS*4-1:0] flow_tag_category_permit,
  input wire [NUM_FLOWS*`PRIO_W-1:0] flow_priority,
  input wire [NUM_FLOWS*4-1:0] flow_action_config,
  input wire [`NM_FLOWS*4-1:0] fallback_action_config,
  // flow enable control writes
  input wire [`LOWER_W-1:0] flow_enable_wr_data,
  input wire enable_set_lower,
  input wire enable_clear_lower,
  input wire enable_toggle_lower,
  input wire enable_set_upper,
  input wire enable_clear_upper,
  input wire enable_toggle_upper,
  output reg [NUM_FLOWS-1:0] flow_enable_control,
  output reg [OCC_W-1:0] pipeline_occupancy,
  // lookup result
  output reg lookup_valid,
  output reg sa_hit,
  output reg [((NUM_FLOWS > 8) ? $clog2(NUM_FLOWS) : 3)-1:0] sa_index,
  // packet out
  output reg out_valid,
  output reg out_sop,
  output reg out_eop,
  output reg [DATA_W-1:0] out_data,
  output reg out_transform,
  output reg [((NUM_FLOWS > 8) ? $clog2(NUM_FLOWS) : 3)-1:0] out_context,
  output reg out_crc_bad,
  output reg out_pkt_err,
  output reg out_frame_abort
);
  localparam IDX_W = (NUM_FLOWS > 8) ? $clog2(NUM_FLOWS) : 3;
  localparam UPPER_W = NUM_FLOWS - `LOWER_W;

  wire [NUM_FLOWS-1:0] flow_hit;
  reg [UPPER_W-1:0] stage_set;
  reg [UPPER_W-1:0] stage_clear;
  reg [UPPER_W-1:0] stage_toggle;
  reg [NUM_FLOWS-1:0] next_enable;
  reg [NUM_FLOWS-1:0] disabled_now;
  reg [OCC_W-1:0] in_flight;
  reg best_found;
  reg [`PRIO_W-1:0] best_prio;
  reg [IDX_W-1:0] best_idx;
  reg [1:0] next_type;
  reg [1:0] next_drop;
  reg [3:0] nm_cfg;
  reg [2:0] nm_sel;
  reg [1:0] act_type;
  reg [1:0] act_drop;
  reg d1_valid;
  reg d1_sop;
  reg d1_eop;
  reg [DATA_W-1:0] d1_data;
  wire pkt_in;
  wire pkt_out;
  integer i;
  genvar f;

  generate
    for (f = 0; f < NUM_FLOWS; f = f + 1) begin : match_units
      flow_matcher #(.INGRESS(INGRESS)) u_match (
        .pkt_key(pkt_key),
        .pkt_tag(pkt_tag),
        .hdr_bypass_mode(hdr_bypass_mode),
        .flow_match_values(flow_match_values[f*`KEY_W +: `KEY_W]),
        .flow_criterion_mask(flow_criterion_mask[f*`MASK_W +: `MASK_W]),
        .flow_tag_category_permit(flow_tag_category_permit[f*4 +: 4]),
        .flow_enabled(flow_enable_control[f]),
        .hit(flow_hit[f])
      );
    end
  endgenerate

  // priority pick; strict greater keeps the lowest index on ties
  always @* begin
    best_found = 1'b0;
    best_prio = {`PRIO_W{1'b0}};
    best_idx = {IDX_W{1'b0}};
    for (i = 0; i < NUM_FLOWS; i = i + 1) begin
      if (flow_hit[i] &&
          (!best_found || flow_priority[i*`PRIO_W +: `PRIO_W] > best_prio)) begin
        best_found = 1'b1;
        best_prio = flow_priority[i*`PRIO_W +: `PRIO_W];
        best_idx = i[IDX_W-1:0];
      end
    end
  end

  // fallback selection by control bit and tag category
  always @* begin
    nm_sel = {pkt_key[`KEY_CTRL_LO], pkt_tag};
    nm_cfg = fallback_action_config[nm_sel*4 +: 4];
    if (best_found) begin
      next_type = flow_action_config[best_idx*4 +: 2];
      next_drop = flow_action_config[best_idx*4+2 +: 2];
    end else begin
      // a transform code in a fallback entry is treated as bypass
      next_type = (nm_cfg[1:0] == `FT_DROP) ? `FT_DROP : `FT_BYPASS;
      next_drop = nm_cfg[3:2];
    end
  end

  // enable control: upper flags staged, applied and zeroed by lower write
  always @* begin
    next_enable = flow_enable_control;
    if (enable_set_lower)
      next_enable = flow_enable_control | {stage_set, flow_enable_wr_data};
    else if (enable_clear_lower)
      next_enable = flow_enable_control & ~{stage_clear, flow_enable_wr_data};
    else if (enable_toggle_lower)
      next_enable = flow_enable_control ^ {stage_toggle, flow_enable_wr_data};
    disabled_now = flow_enable_control & ~next_enable;
  end

  assign pkt_in = in_valid & in_sop;
  assign pkt_out = d1_valid & d1_eop;

  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      flow_enable_control <= {NUM_FLOWS{1'b0}};
      stage_set <= {UPPER_W{1'b0}};
      stage_clear <= {UPPER_W{1'b0}};
      stage_toggle <= {UPPER_W{1'b0}};
    end else begin
      flow_enable_control <= next_enable;
      if (enable_set_upper)
        stage_set <= flow_enable_wr_data[UPPER_W-1:0];
      else if (enable_set_lower)
        stage_set <= {UPPER_W{1'b0}};
      if (enable_clear_upper)
        stage_clear <= flow_enable_wr_data[UPPER_W-1:0];
      else if (enable_clear_lower)
        stage_clear <= {UPPER_W{1'b0}};
      if (enable_toggle_upper)
        stage_toggle <= flow_enable_wr_data[UPPER_W-1:0];
      else if (enable_toggle_lower)
        stage_toggle <= {UPPER_W{1'b0}};
    end
  end

  // packets between lookup and their last word entering the output stage
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      in_flight <= {OCC_W{1'b0}};
      pipeline_occupancy <= {OCC_W{1'b0}};
    end else begin
      in_flight <= in_flight + {{(OCC_W-1){1'b0}}, pkt_in} - {{(OCC_W-1){1'b0}}, pkt_out};
      // load with packets still inside, so the leaving one is not counted
      if (|disabled_now)
        pipeline_occupancy <= in_flight - {{(OCC_W-1){1'b0}}, pkt_out};
      else if (pkt_out && pipeline_occupancy != {OCC_W{1'b0}})
        pipeline_occupancy <= pipeline_occupancy - {{(OCC_W-1){1'b0}}, 1'b1};
    end
  end

  // lookup result, one cycle ahead of the packet's first output word
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      lookup_valid <= 1'b0;
      sa_hit <= 1'b0;
      sa_index <= {IDX_W{1'b0}};
      act_type <= `FT_BYPASS;
      act_drop <= `DROP_CRC;
    end else begin
      lookup_valid <= pkt_in;
      if (pkt_in) begin
        sa_hit <= best_found;
        sa_index <= best_found ? best_idx :
                    {{(IDX_W-3){1'b0}}, pkt_key[`KEY_CTRL_LO], pkt_tag};
        act_type <= next_type;
        act_drop <= next_drop;
      end
    end
  end

  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      d1_valid <= 1'b0;
      d1_sop <= 1'b0;
      d1_eop <= 1'b0;
      d1_data <= {DATA_W{1'b0}};
    end else begin
      d1_valid <= in_valid;
      d1_sop <= in_sop & in_valid;
      d1_eop <= in_eop & in_valid;
      d1_data <= in_data;
    end
  end

  // action stage uses the result registered at this packet's start
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      out_valid <= 1'b0;
      out_sop <= 1'b0;
      out_eop <= 1'b0;
      out_data <= {DATA_W{1'b0}};
      out_transform <= 1'b0;
      out_context <= {IDX_W{1'b0}};
      out_crc_bad <= 1'b0;
      out_pkt_err <= 1'b0;
      out_frame_abort <= 1'b0;
    end else begin
      if (act_type == `FT_DROP && act_drop == `DROP_INTERNAL) begin
        out_valid <= 1'b0;
        out_sop <= 1'b0;
        out_eop <= 1'b0;
      end else begin
        out_valid <= d1_valid;
        out_sop <= d1_sop;
        out_eop <= d1_eop;
      end
      out_data <= d1_data;
      out_transform <= d1_valid && act_type == `FT_XFORM;
      out_context <= sa_index;
      out_crc_bad <= pkt_out && act_type == `FT_DROP && act_drop == `DROP_CRC;
      out_pkt_err <= pkt_out && act_type == `FT_DROP && act_drop == `DROP_PKT_ERR;
      out_frame_abort <= pkt_out && act_type == `FT_DROP &&
                         (act_drop == `DROP_CRC || act_drop == `DROP_PKT_ERR);
    end
  end
endmodule
`default_nettype wire

// file: macsec_sa_flow_lookup_checker.sv
// concurrent checks on the sa flow lookup ports
`default_nettype none
`include "sa_flow_lookup_regs.vh"
module macsec_sa_flow_lookup_checker (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic in_valid,
  input wire logic in_sop,
  input wire logic [63:0] in_data,
  input wire logic [`KEY_W-1:0] pkt_key,
  input wire logic [1:0] pkt_tag,
  input wire logic lookup_valid,
  input wire logic sa_hit,
  input wire logic [5:0] sa_index,
  input wire logic out_valid,
  input wire logic out_sop,
  input wire logic out_eop,
  input wire logic [63:0] out_data,
  input wire logic out_transform,
  input wire logic [5:0] out_context,
  input wire logic out_crc_bad,
  input wire logic out_pkt_err,
  input wire logic out_frame_abort
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  wire sop = in_valid && in_sop;
  chk_lookup_pulse: assert property (sop |=> lookup_valid)
    else $error("lookup missing after packet start");
  chk_no_stray_lookup: assert property (!sop |=> !lookup_valid)
    else $error("lookup without packet start");
  chk_miss_index: assert property (lookup_valid && !sa_hit |->
    sa_index == {3'h0, $past(pkt_key[`KEY_CTRL_LO]), $past(pkt_tag)})
    else $error("miss index not built from control bit and tag");
  chk_result_hold: assert property (!lookup_valid |-> $stable(sa_hit) && $stable(sa_index))
    else $error("lookup result moved without a lookup");
  chk_sop_delay: assert property (out_valid && out_sop |-> $past(sop, 2))
    else $error("output start not two cycles after input start");
  chk_data_pass: assert property (out_valid && !out_transform |->
    out_data == $past(in_data, 2))
    else $error("forwarded word altered");
  chk_xform_hit: assert property (out_sop && out_transform |->
    $past(sa_hit) && out_context == $past(sa_index))
    else $error("transform without a matched flow context");
  chk_crc_abort: assert property (out_crc_bad |-> out_frame_abort && out_eop && out_valid)
    else $error("crc drop without abort on last word");
  chk_err_abort: assert property (out_pkt_err |-> out_frame_abort && out_eop && !out_crc_bad)
    else $error("packet error drop without abort on last word");
  chk_abort_cause: assert property (out_frame_abort |-> out_crc_bad || out_pkt_err)
    else $error("abort without a drop cause");
  cover property (lookup_valid && sa_hit);
  cover property (lookup_valid && !sa_hit);
  cover property (out_frame_abort);
endmodule
bind macsec_sa_flow_lookup macsec_sa_flow_lookup_checker macsec_sa_flow_lookup_checker_inst (
  .sys_clk, .rst, .in_valid, .in_sop, .in_data, .pkt_key, .pkt_tag, .lookup_valid, .sa_hit,
  .sa_index, .out_valid, .out_sop, .out_eop, .out_data, .out_transform, .out_context,
  .out_crc_bad, .out_pkt_err, .out_frame_abort);
`default_nettype wire

// file: pkt_source.sv
// packet source standing in for the classification stage
`default_nettype none
`include "sa_flow_lookup_regs.vh"
module pkt_source (
  input wire logic sys_clk,
  output logic in_valid,
  output logic in_sop,
  output logic in_eop,
  output logic [63:0] in_data,
  output logic [`KEY_W-1:0] pkt_key,
  output logic [1:0] pkt_tag
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    in_valid = 0;
    in_sop = 0;
    in_eop = 0;
    in_data = '0;
    pkt_key = '0;
    pkt_tag = '0;
  end
  task automatic send(logic [`KEY_W-1:0] k, logic [1:0] t, int n, logic [63:0] b);
    for (int i = 0; i < n; i++) begin
      @(negedge sys_clk);
      in_valid = 1;
      in_sop = (i == 0);
      in_eop = (i == n - 1);
      in_data = b + i;
      pkt_key = k;
      pkt_tag = t;
    end
    @(negedge sys_clk);
    // stale lines flip so a leftover word never looks live
    in_valid = 0;
    in_sop = 0;
    in_eop = 0;
    in_data = ~in_data;
    pkt_key = ~pkt_key;
    pkt_tag = ~pkt_tag;
  endtask
endmodule
`default_nettype wire

// file: macsec_sa_flow_lookup_tb.sv
// self-checking bench for the sa flow lookup
`default_nettype none
`include "sa_flow_lookup_regs.vh"
module macsec_sa_flow_lookup_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 0, rst = 1, hdr_bypass_mode = 0;
  logic in_valid, in_sop, in_eop, lookup_valid, sa_hit, out_valid, out_sop, out_eop;
  logic out_transform, out_crc_bad, out_pkt_err, out_frame_abort;
  logic [63:0] in_data, out_data, flow_enable_control;
  logic [`KEY_W-1:0] pkt_key, key = '0;
  logic [1:0] pkt_tag;
  logic [64*`KEY_W-1:0] flow_match_values = '0;
  logic [64*`MASK_W-1:0] flow_criterion_mask = '0;
  logic [255:0] flow_tag_category_permit = '0, flow_priority = '0, flow_action_config = '0;
  logic [31:0] fallback_action_config = 32'h22222222, wd = '0;
  logic [2:0] lo_s = '0, up_s = '0;
  logic [7:0] pipeline_occupancy;
  logic [5:0] sa_index, out_context;
  int fail_count = 0, tests_run = 0;
  pkt_source pkt_source_inst (.sys_clk, .in_valid, .in_sop, .in_eop, .in_data, .pkt_key, .pkt_tag);
  macsec_sa_flow_lookup macsec_sa_flow_lookup_inst (.sys_clk, .rst, .in_valid, .in_sop, .in_eop,
    .in_data, .pkt_key, .pkt_tag, .hdr_bypass_mode, .flow_match_values, .flow_criterion_mask,
    .flow_tag_category_permit, .flow_priority, .flow_action_config, .fallback_action_config,
    .flow_enable_wr_data(wd), .enable_set_lower(lo_s[0]), .enable_clear_lower(lo_s[1]),
    .enable_toggle_lower(lo_s[2]), .enable_set_upper(up_s[0]), .enable_clear_upper(up_s[1]),
    .enable_toggle_upper(up_s[2]), .flow_enable_control, .pipeline_occupancy, .lookup_valid,
    .sa_hit, .sa_index, .out_valid, .out_sop, .out_eop, .out_data, .out_transform, .out_context,
    .out_crc_bad, .out_pkt_err, .out_frame_abort);
  initial forever #5 sys_clk = ~sys_clk;
  task automatic chk(string n, logic [63:0] e, logic [63:0] g);
    tests_run++;
    if (e !== g) begin
      fail_count++;
      $display("MISMATCH %s expected %0h seen %0h", n, e, g);
    end
  endtask
  task automatic flow(int f, logic [3:0] pr, pe, ac);
    flow_priority[f*4+:4] = pr;
    flow_tag_category_permit[f*4+:4] = pe;
    flow_action_config[f*4+:4] = ac;
  endtask
  // upper half staged first, lower write applies both
  task automatic en(int a, logic [31:0] hi, lo);
    @(negedge sys_clk);
    wd = hi;
    up_s[a] = 1;
    @(negedge sys_clk);
    up_s[a] = 0;
    wd = lo;
    lo_s[a] = 1;
    @(negedge sys_clk);
    lo_s[a] = 0;
  endtask
  task automatic look(logic [1:0] t, logic h, logic [5:0] i);
    pkt_source_inst.send(key, t, 1, 64'h0);
    chk("lookup_valid", 1, lookup_valid);
    chk("sa_hit", h, sa_hit);
    chk("sa_index", i, sa_index);
    @(negedge sys_clk);
    chk("out_transform", 0, out_transform);
  endtask
  task automatic t_fallback();
    for (int c = 0; c < 2; c++)
      for (int t = 0; t < 4; t++) begin
        key[`KEY_CTRL_LO] = c[0];
        look(t[1:0], 0, {3'h0, c[0], t[1:0]});
      end
    key = '0;
  endtask
  task automatic t_permit();
    flow(3, 1, 4'h2, 0);
    flow(4, 15, 4'h0, 0);
    en(0, 0, 32'h18);
    chk("enables", 64'h18, flow_enable_control);
    look(1, 1, 3);
    look(0, 0, 0);
  endtask
  task automatic t_mask();
    flow(3, 1, 4'hF, 0);
    flow_criterion_mask[3*96+1] = 1;
    flow_criterion_mask[3*96+6+:6] = '1;
    flow_criterion_mask[3*96+13] = 1;
    flow_criterion_mask[3*96+18] = 1;
    flow_match_values[3*285+112] = 1;
    flow_match_values[3*285+119+:12] = 12'h005;
    key[112] = 1;
    key[130:119] = 12'h005;
    flow_criterion_mask[3*96+20] = 1;
    flow_match_values[3*285+8+:8] = 8'hA5;
    flow_match_values[3*285+48+:8] = 8'h3C;
    flow_match_values[3*285+134+:12] = 12'hABC;
    key[15:8] = 8'hA5;
    key[55:48] = 8'h3C;
    key[145:134] = 12'hABC;
    look(0, 1, 3);
    key[55:48] = 8'h3D;
    look(0, 0, 0);
    key[55:48] = 8'h3C;
    key[134] = 1;
    look(0, 0, 0);
    key = '0;
    flow_criterion_mask = '0;
  endtask
  task automatic t_prio();
    en(1, '1, '1);
    flow(3, 2, 4'hF, 0);
    flow(5, 9, 4'hF, 0);
    flow(7, 9, 4'hF, 0);
    flow(40, 15, 4'hF, 0);
    en(0, 0, 32'hA8);
    look(0, 1, 5);
    en(0, 32'h100, 0);
    chk("enables", 64'h100_0000_00A8, flow_enable_control);
    look(0, 1, 40);
    en(2, 32'h100, 32'h20);
    chk("enables", 64'h88, flow_enable_control);
    look(0, 1, 7);
  endtask
  task automatic t_occ();
    fork
      pkt_source_inst.send(key, 0, 6, 64'h100);
    join_none
    en(1, 0, 32'h8);
    chk("occupancy", 1, pipeline_occupancy);
    for (int i = 0; i < 20 && pipeline_occupancy != 0; i++) @(negedge sys_clk);
    chk("occupancy", 0, pipeline_occupancy);
  endtask
  task automatic t_drop();
    logic [3:0] act[5] = '{4'h0, 4'h1, 4'h5, 4'h9, 4'h2};
    int ab;
    int v;
    int tf;
    en(0, 0, 32'h8);
    for (int a = 0; a < 5; a++) begin
      flow(3, 9, 4'hF, act[a]);
      ab = 0;
      v = 0;
      tf = 0;
      fork
        pkt_source_inst.send(key, 0, 3, 64'h200);
      join_none
      repeat (8) begin
        @(negedge sys_clk);
        ab += out_frame_abort;
        v += out_valid;
        tf += out_transform;
      end
      chk("transform words", (a == 4) ? 3 : 0, tf);
      chk("abort count", (a == 1 || a == 2), ab);
      chk("output words", (a == 3) ? 0 : 3, v);
    end
  endtask
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    #100us;
    fail_count++;
    end_of_test();
  end
  initial begin
    repeat (5) @(negedge sys_clk);
    rst = 0;
    t_fallback();
    t_permit();
    t_mask();
    t_prio();
    t_occ();
    t_drop();
    end_of_test();
  end
endmodule
`default_nettype wire
